// File: src/usr_pkg.sv
// usr_pkg: constants, timing figures and state codes for the
// usb suspend/resume controller.
// assumes a single always-on core clock at the rate given here.
package usr_pkg;

  // core clock rate, in MHz
  localparam int CLK_FREQ_MHZ = 50;

  // documented times, in microseconds
  localparam int IDLE_TIME_US     = 3000;   // idle before suspend
  localparam int OFF_TIME_US      = 2000;   // suspend out to clock stop
  localparam int HOST_K_TIME_US   = 20000;  // host resume K length
  localparam int REMOTE_K_TIME_US = 10000;  // remote wake K length
  localparam int WAKE_MAX_TIME_US = 15000;  // wake to normal, longest

  // derived cycle counts; idle must be strictly longer than its time
  localparam int IDLE_CYC     = IDLE_TIME_US * CLK_FREQ_MHZ + 1;
  localparam int OFF_CYC      = OFF_TIME_US * CLK_FREQ_MHZ;
  localparam int HOST_K_CYC   = HOST_K_TIME_US * CLK_FREQ_MHZ;
  // drive lasts count + 1 cycles, so one less gives the exact length
  localparam int REMOTE_K_CYC = REMOTE_K_TIME_US * CLK_FREQ_MHZ - 1;
  // wake to normal takes count + 2 cycles, so two less meets the bound
  localparam int WAKE_MAX_CYC = WAKE_MAX_TIME_US * CLK_FREQ_MHZ - 2;

  // duration counter width, holds the largest count above
  localparam int CNT_W = 21;

  // timer slots
  localparam int NUM_TMR   = 5;
  localparam int TMR_IDLE  = 0;
  localparam int TMR_OFF   = 1;
  localparam int TMR_HOSTK = 2;
  localparam int TMR_REMK  = 3;
  localparam int TMR_WAKE  = 4;

  // unlock command data value
  localparam logic [15:0] UNLOCK_KEY = 16'hAA37;

  // reset values
  localparam logic RST_REGS_WE = 1'b1;  // writable after power-on
  localparam logic RST_FLAG    = 1'b0;

  // controller states, one-hot
  typedef enum logic [5:0] {
    ST_AWAKE    = 6'h01,
    ST_DETECT   = 6'h02,
    ST_SUSP     = 6'h04,
    ST_SLEEP    = 6'h08,
    ST_WAKE_OSC = 6'h10,
    ST_WAKE_RUN = 6'h20
  } usr_state_t;

endpackage

// File: src/usr_flag_if.sv
// usr_flag_if: event flags between the controller and flag keeper.
// assumes both ends sit in the core clock domain.
`timescale 1ns/10ps
interface usr_flag_if;
  logic set_susp;   // suspend detected pulse
  logic set_res;    // resume detected pulse
  logic ack_susp;   // firmware acknowledge
  logic ack_res;    // firmware acknowledge
  logic en_susp;    // suspend interrupt enable
  logic en_res;     // resume interrupt enable
  logic flag_susp;  // sticky suspend flag
  logic flag_res;   // sticky resume flag
  logic irq;        // combined interrupt
  modport ctrl (output set_susp, set_res, ack_susp, ack_res,
                output en_susp, en_res,
                input  flag_susp, flag_res, irq);
  modport keep (input  set_susp, set_res, ack_susp, ack_res,
                input  en_susp, en_res,
                output flag_susp, flag_res, irq);
endinterface

// File: src/usr_timer.sv
// usr_timer: counts consecutive cycles of run, done at LIMIT.
// assumes run is synchronous to core_clk; drop of run clears it.
`timescale 1ns/10ps
module usr_timer
  import usr_pkg::*;
#(
  parameter int LIMIT = 1
)(
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic run,
  output logic      done
);
  logic [CNT_W-1:0] cnt_r;    // run length so far
  logic [CNT_W-1:0] cnt_nxt;
  logic             at_lim;   // reached, holds

  assign at_lim  = (cnt_r == CNT_W'(LIMIT));
  // saturate so a long run keeps done high
  assign cnt_nxt = !run ? '0 : (at_lim ? cnt_r : cnt_r + 1'b1);
  assign done    = at_lim;

  // count register
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_timer_drop: assert property (!run |=> !done)
    else $error("timer done without continuous run");
  a_timer_hold: assert property (run && done |=> done)
    else $error("timer done lost during run");
endmodule

// File: src/usr_flags.sv
// usr_flags: sticky suspend/resume flags and the gated interrupt.
// assumes set and ack pulses come from the core clock domain.
`timescale 1ns/10ps
module usr_flags
  import usr_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  usr_flag_if.keep  fl
);
  logic susp_r;    // suspend detected
  logic res_r;     // resume detected
  logic susp_nxt;
  logic res_nxt;

  // set wins over a clear in the same cycle
  assign susp_nxt = fl.set_susp | (susp_r & ~fl.ack_susp);
  assign res_nxt  = fl.set_res | (res_r & ~fl.ack_res);

  assign fl.flag_susp = susp_r;
  assign fl.flag_res  = res_r;
  // level, stays while any enabled flag is set
  assign fl.irq = (susp_r & fl.en_susp) | (res_r & fl.en_res);

  // flag registers
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      susp_r <= RST_FLAG;
      res_r  <= RST_FLAG;
    end
    else
    begin
      susp_r <= susp_nxt;
      res_r  <= res_nxt;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_flag_sticky: assert property
    (susp_r && !fl.ack_susp |=> susp_r)
    else $error("suspend flag dropped without acknowledge");
  a_set_wins: assert property
    (fl.set_susp && fl.ack_susp |=> susp_r)
    else $error("suspend event lost to acknowledge");
  a_res_gate: assert property
    (res_r && !fl.en_res && !(susp_r && fl.en_susp) |-> !fl.irq)
    else $error("resume interrupt while disabled");
endmodule

// File: src/usr_susp_ctrl.sv
// usr_susp_ctrl: suspend detect, suspend entry, wake-up and write lock
// for a full-speed usb peripheral.
// assumes an always-on core_clk; the gated internal clocks are the
// osc_enable / clk_distribute outputs. all inputs synchronous.
`timescale 1ns/10ps
module usr_susp_ctrl
  import usr_pkg::*;
#(
  parameter int IDLE_CYCLES   = IDLE_CYC,     // idle limit, cycles
  parameter int OFF_CYCLES    = OFF_CYC,      // clock stop delay
  parameter int HOST_K_CYCLES = HOST_K_CYC,   // host resume K
  parameter int REM_K_CYCLES  = REMOTE_K_CYC, // remote K, minus one
  parameter int WAKE_CYCLES   = WAKE_MAX_CYC  // wake bound
)(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        bus_idle,
  input  wire logic        bus_k_state,
  input  wire logic        wake_in,
  input  wire logic        cs_n,
  input  wire logic        vbus_present,
  input  wire logic        enter_suspend_strobe,
  input  wire logic        internal_clock_run,
  input  wire logic        powered_off_mode,
  input  wire logic        select_wake_enable,
  input  wire logic        suspend_irq_enable,
  input  wire logic        resume_irq_enable,
  input  wire logic        suspend_ack,
  input  wire logic        resume_ack,
  input  wire logic        unlock_valid,
  input  wire logic [15:0] unlock_data,
  input  wire logic        osc_stable,
  output logic             suspend_detected_flag,
  output logic             resume_detected_flag,
  output logic             bus_suspended_status,
  output logic             irq,
  output logic             suspend_out,
  output logic             drive_k_state,
  output logic             osc_enable,
  output logic             clk_distribute,
  output logic             regs_write_enable,
  output logic             normal_op
);

  // timer limits, indexed by the slot constants
  localparam int LIM [NUM_TMR] = '{IDLE_CYCLES, OFF_CYCLES,
                                   HOST_K_CYCLES, REM_K_CYCLES,
                                   WAKE_CYCLES};

  usr_state_t st_r;          // controller state
  usr_state_t st_nxt;        // next state
  logic       go_prev_r;     // go bit, last cycle
  logic       susp_out_r;    // suspend output register
  logic       susp_out_nxt;
  logic       drive_k_r;     // remote wake K drive
  logic       drive_k_nxt;
  logic       regs_we_r;     // register write permission
  logic       regs_we_nxt;

  logic [NUM_TMR-1:0] tmr_run;   // run levels for the timers
  logic [NUM_TMR-1:0] tmr_done;  // limits reached

  // decoded conditions
  logic in_susp;       // suspended, clocks on or off
  logic in_wake;       // wake sequence in progress
  logic go_fall;       // go bit high-to-low
  logic cs_wake;       // qualified select wake
  logic remote_wake;   // application wake request
  logic host_wake;     // long K from host
  logic wake_go;       // leave suspend now
  logic clk_stop;      // clocks may stop
  logic enter_run;     // wake clocks now distributed
  logic unlock_hit;    // valid unlock command

  usr_flag_if fl ();   // event flags to the keeper

  // --- duration timers -------------------------------------------
  // one counter per measured interval; each clears when its run drops
  generate
    for (genvar i = 0; i < NUM_TMR; i++)
    begin : g_tmr
      usr_timer #(
        .LIMIT    (LIM[i])
      ) u_tmr (
        .core_clk (core_clk),
        .reset    (reset),
        .run      (tmr_run[i]),
        .done     (tmr_done[i])
      );
    end
  endgenerate

  // idle must be continuous; any non-idle cycle restarts it
  assign tmr_run[TMR_IDLE]  = bus_idle;
  // clock stop delay runs from suspend entry
  assign tmr_run[TMR_OFF]   = (st_r == ST_SUSP);
  // host resume K measured only while suspended
  assign tmr_run[TMR_HOSTK] = bus_k_state & in_susp;
  // remote K length
  assign tmr_run[TMR_REMK]  = drive_k_r;
  // wake bound from start of wake
  assign tmr_run[TMR_WAKE]  = in_wake;

  // --- decode ----------------------------------------------------
  assign in_susp = (st_r == ST_SUSP) | (st_r == ST_SLEEP);
  assign in_wake = (st_r == ST_WAKE_OSC) | (st_r == ST_WAKE_RUN);

  // level alone does nothing; only the fall starts entry
  assign go_fall = go_prev_r & ~enter_suspend_strobe;

  // select low counts only when enabled and the supply is there
  assign cs_wake = ~cs_n & select_wake_enable & vbus_present;
  assign remote_wake = wake_in | cs_wake;
  assign host_wake   = tmr_done[TMR_HOSTK];
  assign wake_go     = in_susp & (remote_wake | host_wake);

  // powered-off waits the fixed delay; otherwise firmware decides
  // by its clock-run bit, which it clears before going to sleep
  assign clk_stop = powered_off_mode ? tmr_done[TMR_OFF]
                                     : ~internal_clock_run;

  // clocks go out once stable, or at the bound regardless
  assign enter_run = (st_r == ST_WAKE_OSC) &
                     (osc_stable | tmr_done[TMR_WAKE]);

  assign unlock_hit = unlock_valid & (unlock_data == UNLOCK_KEY);

  // --- next state ------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      // normal operation, watching for a long idle
      ST_AWAKE:
      begin
        if (tmr_done[TMR_IDLE])
          st_nxt = ST_DETECT;
      end
      // suspend seen, waiting for firmware's go
      ST_DETECT:
      begin
        if (!tmr_done[TMR_IDLE])
          st_nxt = ST_AWAKE;  // bus came back, entry abandoned
        else if (go_fall)
          st_nxt = ST_SUSP;
      end
      // suspended, clocks still running
      ST_SUSP:
      begin
        if (wake_go)
          st_nxt = ST_WAKE_OSC;
        else if (clk_stop)
          st_nxt = ST_SLEEP;
      end
      // suspended, oscillator and pll off
      ST_SLEEP:
      begin
        if (wake_go)
          st_nxt = ST_WAKE_OSC;
      end
      // oscillator restarting, clocks held back
      ST_WAKE_OSC:
      begin
        if (enter_run)
          st_nxt = ST_WAKE_RUN;
      end
      // clocks out; finish any remote K before normal operation
      ST_WAKE_RUN:
      begin
        if (!drive_k_r)
          st_nxt = ST_AWAKE;
      end
      // a corrupted code recovers to normal operation
      default:
        st_nxt = ST_AWAKE;
    endcase
  end

  // --- output and lock next values -------------------------------
  // suspend out raised at entry in powered-off mode, dropped on wake
  assign susp_out_nxt = enter_run ? 1'b0 :
                        ((st_r == ST_DETECT) & go_fall &
                         tmr_done[TMR_IDLE] & powered_off_mode)
                        ? 1'b1 : susp_out_r;

  // remote K starts with the wake and ends on its own timer
  assign drive_k_nxt = (wake_go & remote_wake) ? 1'b1 :
                       (tmr_done[TMR_REMK] ? 1'b0 : drive_k_r);

  // wake locks; a lock in the same cycle as an unlock wins,
  // since the unlock was meant for the old session
  assign regs_we_nxt = enter_run  ? 1'b0 :
                       unlock_hit ? 1'b1 : regs_we_r;

  // --- registers -------------------------------------------------
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st_r       <= ST_AWAKE;
      go_prev_r  <= 1'b0;
      susp_out_r <= 1'b0;
      drive_k_r  <= 1'b0;
      regs_we_r  <= RST_REGS_WE;
    end
    else
    begin
      st_r       <= st_nxt;
      go_prev_r  <= enter_suspend_strobe;
      susp_out_r <= susp_out_nxt;
      drive_k_r  <= drive_k_nxt;
      regs_we_r  <= regs_we_nxt;
    end
  end

  // --- flags and interrupt ---------------------------------------
  // suspend flag on the awake-to-detect transition only
  assign fl.set_susp = (st_r == ST_AWAKE) & tmr_done[TMR_IDLE];
  // resume flag as wake clocks go out
  assign fl.set_res  = enter_run;
  assign fl.ack_susp = suspend_ack;
  assign fl.ack_res  = resume_ack;
  assign fl.en_susp  = suspend_irq_enable;
  assign fl.en_res   = resume_irq_enable;

  usr_flags u_flags (
    .core_clk (core_clk),
    .reset    (reset),
    .fl       (fl)
  );

  // --- outputs ---------------------------------------------------
  assign suspend_detected_flag = fl.flag_susp;
  assign resume_detected_flag  = fl.flag_res;
  assign irq                   = fl.irq;
  // follows the bus continuously, read by firmware in its handler
  assign bus_suspended_status  = tmr_done[TMR_IDLE];
  assign suspend_out           = susp_out_r;
  assign drive_k_state         = drive_k_r;
  assign osc_enable            = (st_r != ST_SLEEP);
  assign clk_distribute        = ~(st_r == ST_SLEEP) &
                                 ~(st_r == ST_WAKE_OSC);
  assign regs_write_enable     = regs_we_r;
  assign normal_op             = (st_r == ST_AWAKE) |
                                 (st_r == ST_DETECT);

  // --- checks ----------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_susp_detect: assert property
    ($rose(fl.flag_susp) |-> $past(bus_idle, 2))
    else $error("suspend flagged without idle bus");
  a_go_edge: assert property
    ($rose(st_r == ST_SUSP) |->
     $past(go_prev_r) && !$past(enter_suspend_strobe))
    else $error("suspend entered without go falling edge");
  a_pwroff_out: assert property
    (st_r == ST_DETECT && go_fall && tmr_done[TMR_IDLE] &&
     powered_off_mode |=> suspend_out && st_r == ST_SUSP)
    else $error("powered-off entry without suspend output");
  a_clk_off: assert property
    ($fell(osc_enable) && $past(powered_off_mode) |->
     $past(tmr_done[TMR_OFF]))
    else $error("clocks stopped before delay");
  a_cs_qual: assert property
    (st_r == ST_SLEEP && !wake_in && !host_wake &&
     (!select_wake_enable || !vbus_present) |=> st_r == ST_SLEEP)
    else $error("unqualified select woke the device");
  a_k_start: assert property
    ($rose(drive_k_state) |-> $past(in_susp && remote_wake))
    else $error("k drive without remote wake");
  a_clk_stable: assert property
    ($rose(st_r == ST_WAKE_RUN) |->
     $past(osc_stable) || $past(tmr_done[TMR_WAKE]))
    else $error("clocks distributed before stable");
  a_resume_out: assert property
    (enter_run |=> !suspend_out && resume_detected_flag)
    else $error("wake without resume flag or output drop");
  a_wake_bound: assert property
    (st_r == ST_WAKE_OSC && tmr_done[TMR_WAKE] |=>
     st_r == ST_WAKE_RUN)
    else $error("wake overran its bound");
  a_wake_lock: assert property
    (enter_run |=> !regs_write_enable)
    else $error("registers writable after wake");
  a_bad_key: assert property
    (!regs_write_enable && !(unlock_valid &&
     unlock_data == UNLOCK_KEY) |=> !regs_write_enable)
    else $error("lock released without unlock value");

endmodule

// File: test/usr_host_model.sv
// usr_host_model: usb host line states and oscillator start-up.
// assumes mode and dly are set by the bench off the rising edge.
`timescale 1ns/10ps
module usr_host_model
(
  input  wire logic       core_clk,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] dly,
  input  wire logic       osc_enable,
  input  wire logic       drive_k_state,
  output logic            bus_idle,
  output logic            bus_k_state,
  output logic            osc_stable
);
  logic [7:0] cnt_r = 8'h00;  // cycles since oscillator enabled
  logic       tog_r = 1'b0;   // traffic flips j/k every cycle

  // mode 0 traffic, 1 idle, 2 held k; traffic is never seen as idle
  // the device's own remote-wake k also takes the line out of idle
  assign bus_idle    = (mode == 2'h1) & ~drive_k_state;
  assign bus_k_state = (mode == 2'h2) | ((mode == 2'h0) & tog_r) |
                       drive_k_state;
  // dly ff never settles, so the wake bound must force clocks out
  assign osc_stable  = osc_enable & (dly != 8'hFF) & (cnt_r >= dly);

  // start-up count restarts whenever the oscillator is off
  always_ff @(posedge core_clk)
  begin
    tog_r <= ~tog_r;
    cnt_r <= !osc_enable ? 8'h00 : (cnt_r == 8'hFE) ? cnt_r : cnt_r + 8'h01;
  end
endmodule

// File: test/usr_susp_ctrl_tb.sv
// usr_susp_ctrl_tb: self-checking bench for suspend and wake-up.
// assumes the host model for line states and oscillator start-up.
`timescale 1ns/10ps
module usr_susp_ctrl_tb;
  localparam int IDLE = 20;  // shortened counts for the run
  localparam int OFFC = 10;
  localparam int HK   = 30;
  localparam int RK   = 15;
  localparam int WK   = 40;
  // bit positions in obs
  localparam int SF = 0, RF = 1, ST = 2, IRQ = 3, SO = 4;
  localparam int DK = 5, OSC = 6, CLK = 7, RWE = 8, NRM = 9;

  logic        core_clk = 1'b0;  // 50 MHz
  logic        reset    = 1'b1;  // async, active high
  logic        bus_idle, bus_k_state, osc_stable;  // host model
  logic        wake_in, cs_n, vbus_present, enter_suspend_strobe;
  logic        internal_clock_run, powered_off_mode, select_wake_enable;
  logic        suspend_irq_enable, resume_irq_enable;
  logic        suspend_ack, resume_ack, unlock_valid;
  logic [15:0] unlock_data;
  logic        suspend_detected_flag, resume_detected_flag, irq;
  logic        bus_suspended_status, suspend_out, drive_k_state;
  logic        osc_enable, clk_distribute, regs_write_enable, normal_op;
  logic [1:0]  mode;                  // host line request
  logic [7:0]  dly;                   // oscillator start cycles
  logic [31:0] seed = 32'h693ED4FB;   // random state
  logic [9:0]  obs;                   // all outputs
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;               // rising edges so far
  int          t0, t1, n;

  assign obs = {normal_op, regs_write_enable, clk_distribute, osc_enable,
                drive_k_state, suspend_out, irq, bus_suspended_status,
                resume_detected_flag, suspend_detected_flag};

  // clock and edge count
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) cyc++;

  usr_susp_ctrl #(
    .IDLE_CYCLES(IDLE), .OFF_CYCLES(OFFC), .HOST_K_CYCLES(HK),
    .REM_K_CYCLES(RK), .WAKE_CYCLES(WK)
  ) uut (
    .core_clk, .reset, .bus_idle, .bus_k_state, .wake_in, .cs_n,
    .vbus_present, .enter_suspend_strobe, .internal_clock_run,
    .powered_off_mode, .select_wake_enable, .suspend_irq_enable,
    .resume_irq_enable, .suspend_ack, .resume_ack, .unlock_valid,
    .unlock_data, .osc_stable, .suspend_detected_flag,
    .resume_detected_flag, .bus_suspended_status, .irq, .suspend_out,
    .drive_k_state, .osc_enable, .clk_distribute, .regs_write_enable,
    .normal_op
  );
  usr_host_model host (
    .core_clk, .mode, .dly, .osc_enable, .drive_k_state, .bus_idle,
    .bus_k_state, .osc_stable
  );

  // next random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // one comparison, counted
  task automatic chk(input string nm, input logic [15:0] ex,
                     input logic [15:0] got);
    n_tests++;
    if (got !== ex)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // falling-edge wait for obs bit b to reach lv, bounded
  task automatic wait_lv(input int b, input logic lv);
    int k;
    k = 0;
    while (obs[b] !== lv && k < 300)
    begin
      @(negedge core_clk);
      k++;
    end
  endtask

  // one-cycle pulse on a firmware acknowledge
  task automatic ack(input logic s);
    suspend_ack = s;
    resume_ack = !s;
    @(negedge core_clk);
    suspend_ack = 1'b0;
    resume_ack = 1'b0;
    @(negedge core_clk);
  endtask

  // short idle burst, then idle until suspend is detected
  task automatic to_detect();
    mode = 2'h1;
    repeat (IDLE - 2) @(negedge core_clk);
    mode = 2'h0;
    @(negedge core_clk);
    chk("short_idle", 16'h0, 16'(obs[ST]));
    mode = 2'h1;
    t0 = cyc;
    wait_lv(ST, 1'b1);
    n = cyc - t0;
    chk("idle_len", 16'h1, 16'(n >= IDLE && n <= IDLE + 1));
    @(negedge core_clk);
    chk("susp_flag", 16'h1, 16'(obs[SF]));
    chk("susp_irq", 16'(suspend_irq_enable), 16'(obs[IRQ]));
  endtask

  // firmware suspend entry; pw selects powered-off
  task automatic enter(input logic pw);
    powered_off_mode = pw;
    to_detect();
    ack(1'b1);
    chk("flag_ack", 16'h0, 16'(obs[SF] | obs[IRQ]));
    chk("status_rd", 16'h1, 16'(obs[ST]));
    internal_clock_run = pw;
    enter_suspend_strobe = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("strobe_lvl", 16'h1, {14'h0, obs[SO], obs[NRM]});
    enter_suspend_strobe = 1'b0;
    t0 = cyc;
    if (pw)
    begin
      wait_lv(SO, 1'b1);
      chk("so_delay", 16'h1, 16'(cyc - t0 <= 2));
      t0 = cyc;
    end
    wait_lv(OSC, 1'b0);
    n = cyc - t0;
    n = pw ? (n >= OFFC - 1 && n <= OFFC + 1) : (n <= 3);
    chk("clk_off", 16'h1, 16'(n));
    chk("sleep_out", {15'h0, pw}, {14'h0, obs[CLK], obs[SO]});
  endtask

  // wake by src: 0 wake pin, 1 chip select, 2 host k
  task automatic wake(input int src);
    if (src == 1)
    begin
      cs_n = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("cs_no_en", 16'h0, 16'(obs[OSC]));
      select_wake_enable = 1'b1;
      vbus_present = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("cs_no_vbus", 16'h0, 16'(obs[OSC]));
      vbus_present = 1'b1;
    end
    wake_in = (src == 0);
    mode = (src == 2) ? 2'h2 : 2'h1;
    t0 = cyc;
    wait_lv(OSC, 1'b1);
    n = cyc - t0;
    n = (src == 2) ? (n >= HK && n <= HK + 2) : (n <= 2);
    chk("wake_start", 16'h1, 16'(n));
    chk("k_drive", 16'(src != 2), 16'(obs[DK]));
    chk("clk_hold", 16'h0, 16'(obs[CLK]));
    t1 = cyc;
    wait_lv(CLK, 1'b1);
    n = cyc - t1;
    n = (dly == 8'hFF) ? (n >= WK - 2 && n <= WK + 2) : (n <= dly + 2);
    chk("clk_on", 16'h1, 16'(n));
    chk("wake_outs", 16'h2, {13'h0, obs[RWE], obs[RF], obs[SO]});
    chk("res_irq", 16'(resume_irq_enable), 16'(obs[IRQ]));
    if (src != 2)
    begin
      wait_lv(DK, 1'b0);
      chk("k_len", 16'(RK + 1), 16'(cyc - t1));
    end
    wait_lv(NRM, 1'b1);
    chk("normal_by", 16'h1, 16'(cyc - t1 <= WK + 2));
    wake_in = 1'b0;
    cs_n = 1'b1;
    mode = 2'h0;
    internal_clock_run = 1'b1;
    repeat (3)
    begin
      seed = lfsr(seed);
      unlock_data = (seed[15:0] == 16'hAA37) ? 16'h0000 : seed[15:0];
      unlock_valid = 1'b1;
      @(negedge core_clk);
      unlock_valid = 1'b0;
      @(negedge core_clk);
      chk("bad_key", 16'h0, 16'(obs[RWE]));
    end
    unlock_data = 16'hAA37;
    unlock_valid = 1'b1;
    @(negedge core_clk);
    unlock_valid = 1'b0;
    @(negedge core_clk);
    chk("unlock", 16'h1, 16'(obs[RWE]));
    ack(1'b0);
    chk("res_ack", 16'h0, 16'(obs[RF] | obs[IRQ]));
  endtask

  // counts, verdict, end of run
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence: reset, abort, then three suspend/wake rounds
  initial
  begin
    {wake_in, enter_suspend_strobe, select_wake_enable} = 3'h0;
    {suspend_ack, resume_ack, unlock_valid, mode} = 5'h00;
    {cs_n, vbus_present, internal_clock_run, powered_off_mode} = 4'hF;
    {suspend_irq_enable, resume_irq_enable} = 2'h3;
    unlock_data = 16'h0000;
    dly = 8'h04;
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    chk("reset_outs", 16'h03C0, {6'h0, obs});
    to_detect();
    mode = 2'h0;
    t0 = cyc;
    wait_lv(ST, 1'b0);
    chk("status_fall", 16'h1, 16'(cyc - t0 <= 2));
    enter_suspend_strobe = 1'b1;
    @(negedge core_clk);
    enter_suspend_strobe = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("abort", 16'h1, {14'h0, obs[SO], obs[NRM]});
    ack(1'b1);
    for (int r = 0; r < 3; r++)
    begin
      seed = lfsr(seed);
      dly = (r == 2) ? 8'hFF : {5'h0, seed[2:0]} + 8'h02;
      suspend_irq_enable = (r != 1);
      resume_irq_enable = (r != 2);
      enter(r != 1);
      wake(r);
    end
    give_verdict();
  end

  // watchdog, far beyond the few hundred cycles of the rounds
  initial
  begin
    repeat (4000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end
endmodule
